// *** sep_command_port.sv ***
// Serial command port and 256-byte array of a small nonvolatile memory
`timescale 1ns/1ns
`default_nettype none
`include "sep_params.svh"

module sep_command_port
    import sep_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = `SEP_PROG_CYCLES
) (
    // System clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Serial link from the host
    input wire logic scl_clk_i,
    input wire logic cs_i,
    input wire logic ce_i,
    // Open-drain data line
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Status towards the system
    output logic standby_o,
    output logic write_busy_o
);

    // Link-side sequencer state
    sep_state_t state_reg;
    sep_state_t state_next;
    logic [`SEP_BIT_CNT_W-1:0] bit_cnt_reg;
    logic [7:0] rx_sh_reg;
    logic [7:0] cmd_reg;

    // Link-side address, read request and write staging
    logic [`SEP_ADDR_W-1:0] word_address_reg;
    logic [`SEP_ADDR_W-1:0] rd_addr_reg;
    logic req_tog_reg;
    logic [`SEP_ADDR_W-1:0] wr_addr_reg;
    sep_byte_t wr_data_reg [3];
    logic [`SEP_WR_CNT_W-1:0] wr_count_reg;
    logic wr_tag_reg;

    // Link-side busy synchroniser and transmit path
    logic busy_meta_reg;
    logic busy_sync_reg;
    logic status_busy_reg;
    logic [7:0] tx_buf_reg;
    logic out_bit_reg;
    logic drive_reg;

    // System-side synchronisers
    logic cs_meta_reg;
    logic cs_sync_reg;
    logic cs_last_reg;
    logic ce_meta_reg;
    logic ce_sync_reg;
    logic req_meta_reg;
    logic req_sync_reg;
    logic req_last_reg;

    // System-side array, read data and programming engine
    sep_byte_t mem [`SEP_DEPTH];
    sep_byte_t rd_data_reg;
    logic busy_reg;
    logic standby_reg;
    logic last_tag_reg;
    logic [`SEP_PROG_CNT_W-1:0] prog_cnt_reg;
    logic [`SEP_ADDR_W-1:0] prog_addr_reg;
    sep_byte_t prog_data_reg [3];
    logic [`SEP_WR_CNT_W-1:0] prog_count_reg;
    logic [`SEP_WR_CNT_W-1:0] prog_idx_reg;

    // Link reset: select low holds the whole sequencer idle
    logic link_rst_n;
    assign link_rst_n = resetn_i & cs_i;

    // Link-side decode
    logic [7:0] rx_byte;
    logic byte_done;
    logic bit_first;
    logic cmd_done;
    logic addr_done;
    logic wdata_done;
    logic rd_first;
    logic rd_done;
    logic is_cur_read;
    assign rx_byte = {rx_sh_reg[6:0], sda_i};
    assign byte_done = (bit_cnt_reg == 3'd7);
    assign bit_first = (bit_cnt_reg == 3'd0);
    assign cmd_done = (state_reg == SEP_ST_CMD) & byte_done;
    assign addr_done = (state_reg == SEP_ST_ADDR) & byte_done;
    assign wdata_done = (state_reg == SEP_ST_WDATA) & byte_done & (wr_count_reg != `SEP_MAX_WR_BYTES);
    assign rd_first = (state_reg == SEP_ST_RDATA) & bit_first;
    assign rd_done = (state_reg == SEP_ST_RDATA) & byte_done;
    assign is_cur_read = (rx_byte == `SEP_CMD_READ_CUR);

    // Session sequencing per byte boundary
    always_comb begin
        state_next = state_reg;
        if (byte_done) begin
            unique case (state_reg)
                SEP_ST_CMD: begin
                    state_next = SEP_ST_STATUS;
                end
                SEP_ST_STATUS: begin
                    if (status_busy_reg) begin
                        state_next = SEP_ST_IGNORE;
                    end else if (cmd_reg == `SEP_CMD_READ_CUR) begin
                        state_next = SEP_ST_RDATA;
                    end else if (cmd_reg == `SEP_CMD_WRITE_ADDR || cmd_reg == `SEP_CMD_READ_ADDR) begin
                        state_next = SEP_ST_ADDR;
                    end else begin
                        state_next = SEP_ST_IGNORE;
                    end
                end
                SEP_ST_ADDR: begin
                    if (cmd_reg == `SEP_CMD_READ_ADDR) begin
                        state_next = SEP_ST_RDATA;
                    end else begin
                        state_next = SEP_ST_WDATA;
                    end
                end
                SEP_ST_WDATA, SEP_ST_RDATA, SEP_ST_IGNORE: begin
                    state_next = state_reg;
                end
                default: begin
                    state_next = SEP_ST_IGNORE;
                end
            endcase
        end
    end

    // Receive shifter and sequencer, sampled on rising serial clock
    always_ff @(posedge scl_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state_reg <= SEP_ST_CMD;
            bit_cnt_reg <= 3'd0;
            rx_sh_reg <= 8'h00;
            cmd_reg <= 8'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
            rx_sh_reg <= rx_byte;
            state_reg <= state_next;
            if (cmd_done) begin
                cmd_reg <= rx_byte;
            end
        end
    end

    // Busy level into the link domain
    always_ff @(posedge scl_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_meta_reg <= 1'b0;
            busy_sync_reg <= 1'b0;
        end else begin
            busy_meta_reg <= busy_reg;
            busy_sync_reg <= busy_meta_reg;
        end
    end

    // Address pointer and read prefetch requests, kept across sessions
    always_ff @(posedge scl_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            word_address_reg <= 8'h00;
            rd_addr_reg <= 8'h00;
            req_tog_reg <= 1'b0;
        end else begin
            if (cmd_done && is_cur_read) begin
                rd_addr_reg <= word_address_reg;
                req_tog_reg <= ~req_tog_reg;
            end
            if (addr_done) begin
                word_address_reg <= rx_byte;
                if (cmd_reg == `SEP_CMD_READ_ADDR) begin
                    rd_addr_reg <= rx_byte;
                    req_tog_reg <= ~req_tog_reg;
                end
            end
            if (rd_first) begin
                rd_addr_reg <= word_address_reg + 8'h01;
                req_tog_reg <= ~req_tog_reg;
            end
            if (rd_done || wdata_done) begin
                word_address_reg <= word_address_reg + 8'h01;
            end
        end
    end

    // Write staging; held stable after select falls for the commit
    always_ff @(posedge scl_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_addr_reg <= 8'h00;
            wr_count_reg <= 2'd0;
            wr_tag_reg <= 1'b0;
            wr_data_reg[0] <= 8'h00;
            wr_data_reg[1] <= 8'h00;
            wr_data_reg[2] <= 8'h00;
        end else begin
            if (cmd_done) begin
                wr_count_reg <= 2'd0;
            end
            if (addr_done) begin
                wr_addr_reg <= rx_byte;
            end
            if (wdata_done) begin
                wr_data_reg[wr_count_reg] <= rx_byte;
                wr_count_reg <= wr_count_reg + 2'd1;
                if (wr_count_reg == 2'd0) begin
                    wr_tag_reg <= ~wr_tag_reg; // Only sessions that carry data arm a commit
                end
            end
        end
    end

    // Transmit byte selection at the start of each sent byte
    logic tx_status_load;
    logic tx_read_load;
    sep_byte_t status_byte;
    sep_byte_t tx_byte;
    assign tx_status_load = (state_reg == SEP_ST_STATUS) & bit_first;
    assign tx_read_load = (state_reg == SEP_ST_RDATA) & bit_first;
    assign status_byte = busy_sync_reg ? `SEP_STATUS_BUSY : `SEP_STATUS_READY;
    assign tx_byte = tx_status_load ? status_byte : (tx_read_load ? rd_data_reg : tx_buf_reg);

    // Transmit shifter, updated on falling serial clock
    always_ff @(negedge scl_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_buf_reg <= 8'h00;
            out_bit_reg <= 1'b1;
            drive_reg <= 1'b0;
            status_busy_reg <= 1'b0;
        end else begin
            tx_buf_reg <= tx_byte;
            out_bit_reg <= tx_byte[~bit_cnt_reg];
            drive_reg <= (state_reg == SEP_ST_STATUS) | (state_reg == SEP_ST_RDATA);
            if (tx_status_load) begin
                status_busy_reg <= busy_sync_reg;
            end
        end
    end

    // Open-drain drive: pull low only for a zero bit
    assign sda_o = 1'b0;
    assign sda_oe_o = drive_reg & ~out_bit_reg;

    // System-side synchronisers for select, enable and read requests
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cs_meta_reg <= 1'b0;
            cs_sync_reg <= 1'b0;
            cs_last_reg <= 1'b0;
            ce_meta_reg <= 1'b0;
            ce_sync_reg <= 1'b0;
            req_meta_reg <= 1'b0;
            req_sync_reg <= 1'b0;
            req_last_reg <= 1'b0;
        end else begin
            cs_meta_reg <= cs_i;
            cs_sync_reg <= cs_meta_reg;
            cs_last_reg <= cs_sync_reg;
            ce_meta_reg <= ce_i;
            ce_sync_reg <= ce_meta_reg;
            req_meta_reg <= req_tog_reg;
            req_sync_reg <= req_meta_reg;
            req_last_reg <= req_sync_reg;
        end
    end

    // System-side events
    logic cs_fall;
    logic req_evt;
    logic commit;
    logic prog_we;
    logic prog_last;
    logic [`SEP_ADDR_W-1:0] prog_wr_addr;
    assign cs_fall = cs_last_reg & ~cs_sync_reg;
    assign req_evt = req_sync_reg ^ req_last_reg;
    assign commit = cs_fall & ~busy_reg & (wr_count_reg != 2'd0) & (wr_tag_reg != last_tag_reg);
    assign prog_we = busy_reg & (prog_cnt_reg == 20'd0);
    assign prog_last = (prog_idx_reg == prog_count_reg - 2'd1);
    assign prog_wr_addr = prog_addr_reg + {6'd0, prog_idx_reg};

    // Read data for the link, quasi-static between requests
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data_reg <= 8'h00;
        end else if (req_evt) begin
            rd_data_reg <= mem[rd_addr_reg];
        end
    end

    // Programming engine: copy staging, wait, then write byte by byte
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_reg <= 1'b0;
            last_tag_reg <= 1'b0;
            prog_cnt_reg <= 20'd0;
            prog_addr_reg <= 8'h00;
            prog_count_reg <= 2'd0;
            prog_idx_reg <= 2'd0;
            prog_data_reg[0] <= 8'h00;
            prog_data_reg[1] <= 8'h00;
            prog_data_reg[2] <= 8'h00;
        end else if (commit) begin
            busy_reg <= 1'b1;
            last_tag_reg <= wr_tag_reg;
            prog_cnt_reg <= 20'(PROG_CYCLES - 1);
            prog_addr_reg <= wr_addr_reg;
            prog_count_reg <= wr_count_reg;
            prog_idx_reg <= 2'd0;
            prog_data_reg[0] <= wr_data_reg[0];
            prog_data_reg[1] <= wr_data_reg[1];
            prog_data_reg[2] <= wr_data_reg[2];
        end else if (busy_reg && prog_cnt_reg != 20'd0) begin
            prog_cnt_reg <= prog_cnt_reg - 20'd1;
        end else if (prog_we) begin
            prog_idx_reg <= prog_idx_reg + 2'd1;
            if (prog_last) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // Array of 256 bytes, one write port for the programming engine
    always_ff @(posedge clk_i) begin
        if (prog_we) begin
            mem[prog_wr_addr] <= prog_data_reg[prog_idx_reg];
        end
    end

    // Standby when enable and select are both low
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            standby_reg <= 1'b0;
        end else begin
            standby_reg <= ~ce_sync_reg & ~cs_sync_reg;
        end
    end

    assign standby_o = standby_reg;
    assign write_busy_o = busy_reg;

endmodule
`default_nettype wire

// *** sep_params.svh ***
// Constants of the serial memory command port: codes, sizes and timing counts
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH

// Command byte codes
`define SEP_CMD_WRITE_ADDR 8'h00
`define SEP_CMD_READ_CUR 8'h80
`define SEP_CMD_READ_ADDR 8'hc0

// Status byte values
`define SEP_STATUS_READY 8'h00
`define SEP_STATUS_BUSY 8'hff

// Array and staging sizes
`define SEP_ADDR_W 8
`define SEP_DATA_W 8
`define SEP_DEPTH 256
`define SEP_MAX_WR_BYTES 2'd3
`define SEP_WR_CNT_W 2
`define SEP_BIT_CNT_W 3

// Clock rate and internal programming time
`define SEP_CLK_PERIOD_NS 8
`define SEP_PROG_TIME_US 5000
`define SEP_PROG_CYCLES ((`SEP_PROG_TIME_US * 1000) / `SEP_CLK_PERIOD_NS)
`define SEP_PROG_CNT_W 20

`endif

// *** sep_pkg.sv ***
// Types of the serial memory command port
package sep_pkg;

    // Session phase of the link-side sequencer
    typedef enum logic [2:0] {
        SEP_ST_CMD    = 3'b000,
        SEP_ST_STATUS = 3'b001,
        SEP_ST_ADDR   = 3'b010,
        SEP_ST_WDATA  = 3'b011,
        SEP_ST_RDATA  = 3'b100,
        SEP_ST_IGNORE = 3'b101
    } sep_state_t;

    // One stored byte
    typedef logic [7:0] sep_byte_t;

endpackage

// *** sep_host_model.sv ***
// Host side of the link: select, enable, serial clock and byte exchange
`timescale 1ns/1ns
`default_nettype none
module sep_host_model (
    // Host pins
    output logic scl_o,
    output logic cs_o,
    output logic ce_o,
    output logic sda_drv_o,
    // Resolved data line
    input wire logic sda_i
);
    // Clock idles low, line released, memory deselected
    initial begin
        scl_o = 1'b0;
        cs_o = 1'b0;
        ce_o = 1'b0;
        sda_drv_o = 1'b1;
    end
    // Enable change only while select is low
    task automatic set_ce(input logic v);
        ce_o <= v;
    endtask
    // Enable first, then select before any byte
    task automatic open_s();
        ce_o <= 1'b1;
        #20 cs_o <= 1'b1;
    endtask
    // One byte each way, MSB first, ones leave the line released
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sda_drv_o <= tx[i];
            #62 scl_o <= 1'b1;
            rx[i] = sda_i;
            #63 scl_o <= 1'b0;
        end
    endtask
    // Select drops after the last byte, and the line is released in the same step
    task automatic close_s();
        #62 cs_o <= 1'b0;
        sda_drv_o <= 1'b1;
        #62;
    endtask
endmodule
`default_nettype wire

// *** sep_command_port_props.sv ***
// Pin-level checks of the serial memory command port
`timescale 1ns/1ns
`default_nettype none
`include "sep_params.svh"
module sep_command_port_props #(
    parameter int unsigned PROG_CYCLES = `SEP_PROG_CYCLES
) (
    // Clocks and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic scl_clk_i,
    // Link and status pins
    input wire logic cs_i,
    input wire logic ce_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic standby_o,
    input wire logic write_busy_o
);
    logic [7:0] bit_reg;
    logic [7:0] cmd_reg;
    logic [31:0] busy_reg;
    // Bit position and command of the session
    always_ff @(posedge scl_clk_i or negedge cs_i) begin
        if (!cs_i) begin
            bit_reg <= 8'h00;
            cmd_reg <= 8'h00;
        end else begin
            bit_reg <= (bit_reg == 8'hff) ? bit_reg : bit_reg + 8'h01;
            cmd_reg <= (bit_reg < 8'h08) ? {cmd_reg[6:0], sda_i} : cmd_reg;
        end
    end
    // Length of the programming pulse
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_reg <= 32'h0;
        end else begin
            busy_reg <= write_busy_o ? busy_reg + 32'h1 : 32'h0;
        end
    end
    sequence s_both_low;
        (!ce_i && !cs_i) [*5];
    endsequence
    sequence s_either_high;
        (ce_i || cs_i) [*5];
    endsequence
    a_open_drain:
        assert property (@(posedge clk_i) disable iff (!resetn_i) !sda_o)
        else $error("data line driven high");
    a_standby_enter:
        assert property (@(posedge clk_i) disable iff (!resetn_i) s_both_low |-> standby_o)
        else $error("standby missing");
    a_standby_leave:
        assert property (@(posedge clk_i) disable iff (!resetn_i) s_either_high |-> !standby_o)
        else $error("standby while active");
    a_deselect_quiet:
        assert property (@(posedge clk_i) disable iff (!resetn_i) (!cs_i) [*2] |-> !sda_oe_o)
        else $error("line driven while deselected");
    a_prog_after_cs:
        assert property (@(posedge clk_i) disable iff (!resetn_i) $rose(write_busy_o) |-> !cs_i)
        else $error("programming began with select high");
    a_prog_length:
        assert property (@(posedge clk_i) disable iff (!resetn_i)
            $fell(write_busy_o) |-> busy_reg >= PROG_CYCLES && busy_reg <= PROG_CYCLES + 8)
        else $error("programming length wrong");
    a_cmd_quiet:
        assert property (@(posedge scl_clk_i) disable iff (!resetn_i || !cs_i) bit_reg < 8'h08 |-> !sda_oe_o)
        else $error("line driven during command");
    a_status_steady:
        assert property (@(posedge scl_clk_i) disable iff (!resetn_i || !cs_i)
            bit_reg inside {[8'h09:8'h0f]} |-> sda_oe_o == $past(sda_oe_o))
        else $error("status bits differ");
    a_write_quiet:
        assert property (@(posedge scl_clk_i) disable iff (!resetn_i || !cs_i) bit_reg >= 8'h10 &&
            (cmd_reg == `SEP_CMD_WRITE_ADDR || (cmd_reg == `SEP_CMD_READ_ADDR && bit_reg < 8'h18)) |-> !sda_oe_o)
        else $error("line driven while host sends");
endmodule
bind sep_command_port sep_command_port_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.clk_i(clk_i),
    .resetn_i(resetn_i), .scl_clk_i(scl_clk_i), .cs_i(cs_i), .ce_i(ce_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .standby_o(standby_o), .write_busy_o(write_busy_o));
`default_nettype wire

// *** sep_command_port_test.sv ***
// Self-checking bench of the serial memory command port
`timescale 1ns/1ns
`default_nettype none
`include "sep_params.svh"
module sep_command_port_test;
    import sep_pkg::*;
    localparam int PROG = 400;
    logic clk_i;
    logic resetn_i;
    wire logic scl, cs, ce, sda_drv, sda;
    logic sda_o, sda_oe, standby, busy;
    int n_mismatch, check_count, cycles;
    logic [7:0] mem_m [256];
    logic [7:0] addr_m, st, rx, a;
    int n_bytes;
    // Pull-up line, low when either side pulls
    assign sda = sda_drv && !(sda_oe && !sda_o);
    sep_command_port #(.PROG_CYCLES(PROG)) dut (.clk_i(clk_i), .resetn_i(resetn_i), .scl_clk_i(scl),
        .cs_i(cs), .ce_i(ce), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .standby_o(standby),
        .write_busy_o(busy));
    sep_host_model host (.scl_o(scl), .cs_o(cs), .ce_o(ce), .sda_drv_o(sda_drv), .sda_i(sda));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Expected read byte: array data for read codes, released line otherwise
    function automatic logic [7:0] exp_rd(input logic [7:0] cmd, input logic [7:0] ad);
        return (cmd == `SEP_CMD_READ_CUR || cmd == `SEP_CMD_READ_ADDR) ? mem_m[ad] : 8'hff;
    endfunction
    // Programming pulse seen or not, then waits for its end
    task automatic wait_prog(input logic exp);
        int t;
        t = 0;
        while (busy !== 1'b1 && t < 40) begin
            @(posedge clk_i);
            t++;
        end
        check({7'h0, busy}, {7'h0, exp});
        t = 0;
        while (busy !== 1'b0 && t < PROG + 60) begin
            @(posedge clk_i);
            t++;
        end
    endtask
    // Write session; bytes are always sent, kept only when ready
    task automatic wr(input logic [7:0] ad, input int n, input logic bsy);
        logic [7:0] d;
        host.open_s();
        host.xfer(`SEP_CMD_WRITE_ADDR, rx);
        host.xfer(8'hff, st);
        check(st, bsy ? `SEP_STATUS_BUSY : `SEP_STATUS_READY);
        host.xfer(ad, rx);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            host.xfer(d, rx);
            if (!bsy && k < 3) mem_m[ad + 8'(k)] = d;
        end
        if (!bsy) addr_m = ad + 8'(n > 3 ? 3 : n);
        host.close_s();
    endtask
    // Read session; addressed form sends the start address first
    task automatic rd(input logic [7:0] cmd, input logic [7:0] ad, input int n);
        host.open_s();
        host.xfer(cmd, rx);
        host.xfer(8'hff, st);
        check(st, `SEP_STATUS_READY);
        if (cmd == `SEP_CMD_READ_ADDR) begin
            host.xfer(ad, rx);
            addr_m = ad;
        end
        for (int k = 0; k < n; k++) begin
            host.xfer(8'hff, rx);
            check(rx, exp_rd(cmd, addr_m));
            if (exp_rd(cmd, addr_m) !== 8'hff || cmd != 8'h40) addr_m++;
        end
        host.close_s();
    endtask
    // Cut a hang short
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        n_mismatch = 0;
        check_count = 0;
        cycles = 0;
        addr_m = 8'h00;
        resetn_i = 1'b0;
        void'($urandom(32'h62a48d4f));
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        check({7'h0, standby}, 8'h01);
        host.set_ce(1'b1);
        repeat (8) @(posedge clk_i);
        check({7'h0, standby}, 8'h00);
        // Writes at both ends of the array, read wrapping through zero
        wr(8'hfd, 3, 1'b0);
        wait_prog(1'b1);
        wr(8'h00, 3, 1'b0);
        wait_prog(1'b1);
        rd(`SEP_CMD_READ_ADDR, 8'hfe, 4);
        rd(`SEP_CMD_READ_CUR, 8'h00, 1);
        // Fourth data byte is dropped
        wr(8'h13, 1, 1'b0);
        wait_prog(1'b1);
        wr(8'h10, 4, 1'b0);
        wait_prog(1'b1);
        rd(`SEP_CMD_READ_ADDR, 8'h10, 4);
        // Session during programming is refused and programs nothing
        wr(8'h40, 1, 1'b0);
        wr(8'h41, 2, 1'b1);
        wait_prog(1'b0);
        rd(`SEP_CMD_READ_ADDR, 8'h40, 1);
        // Address only: no programming, address held
        wr(8'h22, 1, 1'b0);
        wait_prog(1'b1);
        wr(8'h22, 0, 1'b0);
        wait_prog(1'b0);
        rd(`SEP_CMD_READ_CUR, 8'h00, 1);
        // Unknown code leaves the line released
        rd(8'h40, 8'h00, 1);
        // Random writes read back, only the bytes written
        repeat (6) begin
            a = 8'($urandom);
            n_bytes = 1 + int'($urandom % 3);
            wr(a, n_bytes, 1'b0);
            wait_prog(1'b1);
            rd(`SEP_CMD_READ_ADDR, a, n_bytes);
        end
        host.set_ce(1'b0);
        repeat (8) @(posedge clk_i);
        check({7'h0, standby}, 8'h01);
        final_report();
    end
endmodule
`default_nettype wire
